// [hdl/panel_meter_command_layer.sv]
// command interpreter of the panel meter with an AHB-Lite register port
`timescale 1ns/1ps
module panel_meter_command_layer (
  input logic clk,
  input logic rst,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input logic key_init_pin,
  input logic calib_pin,
  input logic nv_fail_pin,
  input logic [31:0] process_value,
  input logic [31:0] status_word,
  output meter_pkg::flags_t flags,
  output logic sw_reset,
  output logic [31:0] remote_value,
  output logic remote_strobe,
  output logic param_wr
);

  meter_pkg::state_t q;
  meter_pkg::state_t d;
  meter_pkg::pins_t pins;

  // ==========================================================================
  // pin synchronisers
  pin_sync #(.W(3)) u_sync (
    .clk(clk),
    .rst(rst),
    .pin_in({calib_pin, nv_fail_pin, key_init_pin}),
    .level_out(pins)
  );

  // ==========================================================================
  // helpers
  function automatic logic [15:0] addr_max(input logic [7:0] vt);
    if (vt == meter_pkg::VT_C0)
      return meter_pkg::MAX_C0;
    else if (vt == meter_pkg::VT_C1)
      return meter_pkg::MAX_C1;
    else if (vt == meter_pkg::VT_C2)
      return meter_pkg::MAX_C2;
    else
      return meter_pkg::MAX_C3;
  endfunction

  function automatic logic op_valid(input logic [7:0] ic,
                                    input logic [7:0] rel);
    if (ic == meter_pkg::IC_WREN || ic == meter_pkg::IC_FZERO)
      return rel == meter_pkg::REL_OFF || rel == meter_pkg::REL_ON;
    else if (ic == meter_pkg::IC_RESET || ic == meter_pkg::IC_AREA1 ||
             ic == meter_pkg::IC_PROTECT)
      return rel == meter_pkg::REL_OFF;
    else
      return 1'b0;
  endfunction

  function automatic logic [31:0] reg_read(input meter_pkg::state_t s,
                                           input logic [7:0] a);
    if (a == meter_pkg::OFF_REQ)
      return s.req;
    else if (a == meter_pkg::OFF_ARG0)
      return s.arg0;
    else if (a == meter_pkg::OFF_ARG1)
      return s.arg1;
    else if (a == meter_pkg::OFF_WDATA)
      return s.wdata;
    else if (a == meter_pkg::OFF_RESP)
      return s.resp;
    else if (a == meter_pkg::OFF_RDATA)
      return s.rdata;
    else if (a == meter_pkg::OFF_STAT)
      return {25'h0000000, s.unknown, s.st == meter_pkg::ST_EXEC, s.flags};
    else
      return 32'h00000000;
  endfunction

  // ==========================================================================
  // next state
  always_comb
  begin
    logic [7:0] mc;
    logic [7:0] sc;
    logic [15:0] len;
    logic [15:0] exp_len;
    logic [7:0] ic;
    logic [7:0] rel;
    logic [7:0] vt;
    logic [15:0] va;
    logic [15:0] rc;
    logic [31:0] rv;
    logic ru;
    logic is_op;
    logic is_var;
    mc = q.req[meter_pkg::REQ_MAIN_LSB +: 8];
    sc = q.req[7:0];
    len = q.req[meter_pkg::REQ_LEN_LSB +: 16];
    ic = q.arg0[15:8];
    rel = q.arg0[7:0];
    vt = q.arg0[meter_pkg::ARG_TYPE_LSB +: 8];
    va = q.arg0[meter_pkg::ARG_ADDR_LSB +: 16];
    is_op = mc == meter_pkg::MAIN_OP && sc == meter_pkg::SUB_OP; // RULE1
    is_var = mc == meter_pkg::MAIN_VAR &&
             (sc == meter_pkg::SUB_RD || sc == meter_pkg::SUB_WR);
    exp_len = (sc == meter_pkg::SUB_RD) ? meter_pkg::VRD_LEN
                                        : meter_pkg::VWR_LEN;
    rc = meter_pkg::RC_OK; // RULE10
    rv = 32'h00000000;
    ru = 1'b0;
    d = q;
    d.sw_reset = 1'b0;
    d.remote_strobe = 1'b0;
    d.param_wr = 1'b0;
    d.hreadyout = 1'b1;
    d.ap_wr = 1'b0;
    // zero-wait slave; read data is fetched in the address phase
    if (hsel && hready && htrans[1])
    begin
      d.ap_wr = hwrite;
      d.ap_addr = haddr[7:0];
      if (!hwrite)
      begin
        d.hrdata = reg_read(q, haddr[7:0]);
      end
    end
    // writes land in the data phase; unmapped writes and GO writes while executing are dropped
    if (q.ap_wr)
    begin
      if (q.ap_addr == meter_pkg::OFF_REQ)
        d.req = hwdata;
      else if (q.ap_addr == meter_pkg::OFF_ARG0)
        d.arg0 = hwdata;
      else if (q.ap_addr == meter_pkg::OFF_ARG1)
        d.arg1 = hwdata;
      else if (q.ap_addr == meter_pkg::OFF_WDATA)
        d.wdata = hwdata;
      else if (q.ap_addr == meter_pkg::OFF_GO && q.st == meter_pkg::ST_IDLE)
        d.st = meter_pkg::ST_EXEC;
    end
    // result decode
    if (is_op)
    begin
      if (len > meter_pkg::OP_LEN)
        rc = meter_pkg::RC_LONG; // RULE6
      else if (len < meter_pkg::OP_LEN)
        rc = meter_pkg::RC_SHORT; // RULE7
      else if (!op_valid(ic, rel))
        rc = meter_pkg::RC_PARAM; // RULE8
      else if (pins.calib || pins.nv_fail || // RULE17
               (ic != meter_pkg::IC_WREN && !q.flags.wr_en) ||
               (q.flags.area1 && ic == meter_pkg::IC_PROTECT) ||
               (q.flags.area1 && ic == meter_pkg::IC_FZERO &&
                rel == meter_pkg::REL_ON))
        rc = meter_pkg::RC_OPERR; // RULE9
    end
    else if (is_var)
    begin
      if (len > exp_len)
        rc = meter_pkg::RC_LONG;
      else if (len < exp_len)
        rc = meter_pkg::RC_SHORT;
      else if (sc == meter_pkg::SUB_WR && vt == meter_pkg::VT_C0)
        rc = meter_pkg::RC_RDONLY;
      else if (vt < meter_pkg::VT_C0 || vt > meter_pkg::VT_C3)
        rc = meter_pkg::RC_TYPE;
      else if (rel != meter_pkg::REL_OFF || q.arg1[15:0] != meter_pkg::ELEM_ONE)
        rc = meter_pkg::RC_PARAM;
      else if (va > addr_max(vt))
        rc = meter_pkg::RC_ADDR;
      else if (pins.calib)
        rc = meter_pkg::RC_OPERR; // RULE17
      else if (sc == meter_pkg::SUB_RD)
      begin
        // parameter reads answer in both areas; only C0 carries live data
        if (vt == meter_pkg::VT_C0)
        begin
          rv = (va == meter_pkg::ADDR_PV) ? process_value : status_word;
          ru = q.flags.area1; // RULE18 RULE19
        end
      end
      else if (!q.flags.wr_en || pins.nv_fail || // RULE9
               (vt == meter_pkg::VT_C1 && (!q.flags.protect || q.flags.area1))
               || (vt == meter_pkg::VT_C3 && !q.flags.area1)) // RULE13 RULE14
        rc = meter_pkg::RC_OPERR;
    end
    else
    begin
      rc = meter_pkg::RC_PARAM;
    end
    // execute
    case (q.st)
      meter_pkg::ST_IDLE:
      begin
      end
      meter_pkg::ST_EXEC:
      begin
        d.st = meter_pkg::ST_IDLE;
        d.resp = {mc, sc, rc}; // RULE5
        if (rc == meter_pkg::RC_OK && is_op) // RULE22
        begin
          case (ic)
            meter_pkg::IC_WREN: d.flags.wr_en = rel[0]; // RULE2
            meter_pkg::IC_FZERO: d.flags.fzero = rel[0]; // RULE3
            meter_pkg::IC_RESET: // RULE4 RULE11
            begin
              d.flags = meter_pkg::FLAGS_RST;
              d.sw_reset = 1'b1;
            end
            meter_pkg::IC_AREA1: d.flags.area1 = 1'b1; // RULE16
            meter_pkg::IC_PROTECT: d.flags.protect = 1'b1;
            default:
            begin
            end
          endcase
        end
        else if (rc == meter_pkg::RC_OK && sc == meter_pkg::SUB_RD)
        begin
          d.rdata = rv;
          d.unknown = ru;
        end
        else if (rc == meter_pkg::RC_OK)
        begin
          if (vt == meter_pkg::VT_C2 && va == meter_pkg::ADDR_RIN &&
              !q.flags.area1) // RULE20
          begin
            d.remote_value = q.wdata;
            d.remote_strobe = 1'b1;
          end
          d.param_wr = vt != meter_pkg::VT_C2;
        end
      end
      default: d.st = meter_pkg::ST_IDLE;
    endcase
    // key entry last, so it wins over a same-cycle software reset
    d.key_q = pins.key_init;
    if (pins.key_init && !q.key_q)
    begin
      d.flags.area1 = 1'b1; // RULE15
    end
    d.flags.measuring = !d.flags.area1; // RULE12
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= meter_pkg::STATE_RST;
    else
      q <= d;
  end

  // ==========================================================================
  // outputs
  assign hrdata = q.hrdata;
  assign hreadyout = q.hreadyout;
  assign hresp = 1'b0;
  assign flags = q.flags;
  assign sw_reset = q.sw_reset;
  assign remote_value = q.remote_value;
  assign remote_strobe = q.remote_strobe;
  assign param_wr = q.param_wr;

  // ==========================================================================
  // checks
  logic ex;
  logic ex_op;
  logic env_ok;
  logic key_rise;
  assign ex = q.st == meter_pkg::ST_EXEC;
  assign ex_op = ex && q.req[15:0] == {meter_pkg::MAIN_OP, meter_pkg::SUB_OP};
  assign env_ok = !pins.calib && !pins.nv_fail;
  assign key_rise = pins.key_init && !q.key_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence op_s(logic [7:0] c, logic [7:0] r);
    ex_op && q.req[31:16] == meter_pkg::OP_LEN && q.arg0[15:8] == c &&
    q.arg0[7:0] == r;
  endsequence

  sequence reset_done_s;
    !q.flags.area1 && q.sw_reset ##1 !q.sw_reset;
  endsequence

  hdr_echo_a: assert property (ex_op |=> // RULE5
    q.resp[31:16] == {meter_pkg::MAIN_OP, meter_pkg::SUB_OP})
    else $error("reply header not echoed");
  wren_on_a: assert property (op_s(meter_pkg::IC_WREN, // RULE2
    meter_pkg::REL_ON) ##0 env_ok |=> q.flags.wr_en)
    else $error("write permission not set");
  fzero_off_a: assert property (op_s(meter_pkg::IC_FZERO, // RULE3
    meter_pkg::REL_OFF) ##0 (env_ok && q.flags.wr_en) |=> !q.flags.fzero)
    else $error("forced zero not cancelled");
  long_frame_a: assert property (ex_op && // RULE6
    q.req[31:16] > meter_pkg::OP_LEN |=> q.resp[15:0] == meter_pkg::RC_LONG)
    else $error("long frame not reported");
  short_frame_a: assert property (ex_op && // RULE7
    q.req[31:16] < meter_pkg::OP_LEN |=> q.resp[15:0] == meter_pkg::RC_SHORT)
    else $error("short frame not reported");
  bad_info_a: assert property (op_s(meter_pkg::IC_AREA1, // RULE8
    meter_pkg::REL_ON) |=> q.resp[15:0] == meter_pkg::RC_PARAM)
    else $error("bad related info accepted");
  no_wren_a: assert property (op_s(meter_pkg::IC_AREA1, // RULE9
    meter_pkg::REL_OFF) ##0 !q.flags.wr_en |=>
    q.resp[15:0] == meter_pkg::RC_OPERR)
    else $error("move accepted without permission");
  area_move_a: assert property (op_s(meter_pkg::IC_AREA1, // RULE12
    meter_pkg::REL_OFF) ##0 (env_ok && q.flags.wr_en) |=>
    q.flags.area1 && !q.flags.measuring)
    else $error("area 1 move did not stop measuring");
  reset_area_a: assert property (op_s(meter_pkg::IC_RESET, // RULE11
    meter_pkg::REL_OFF) ##0 (env_ok && q.flags.wr_en && !key_rise) |=>
    reset_done_s)
    else $error("software reset did not return to area 0");
  err_hold_a: assert property (ex && !key_rise ##1 // RULE22
    q.resp[15:0] != meter_pkg::RC_OK |-> $stable(q.flags))
    else $error("state changed on error result");
  pv_unknown_a: assert property (ex && q.req[15:0] == 16'h0101 && // RULE18
    q.arg0 == 32'hC0000100 && q.arg1[15:0] == meter_pkg::ELEM_ONE &&
    q.req[31:16] == meter_pkg::VRD_LEN && q.flags.area1 && !pins.calib
    |=> q.unknown)
    else $error("process value not flagged unknown");
  remote_hold_a: assert property (ex && q.req[15:0] == 16'h0102 && // RULE20
    q.arg0[31:8] == 24'hC20000 && q.flags.area1 |=> !q.remote_strobe)
    else $error("display changed in area 1");

endmodule

// [hdl/meter_pkg.sv]
// package: register map, codes and types of the panel meter command layer
// Overview of operation
// [RULE1] operation instruction: main 30, sub 05, instruction code, related info
// [RULE2] code 00 clears or sets the remote write permission with 00 or 01
// [RULE3] code 03 with 01 starts forced zero, with 00 cancels it
// [RULE4] with info 00: code 06 resets, 07 moves to area 1, 08 protect
// [RULE5] reply echoes 30 and 05 followed by a four-character result code
// [RULE6] too many characters in an instruction frame gives result 1001
// [RULE7] too few characters in an instruction frame gives result 1002
// [RULE8] unknown instruction code or bad related info gives result 1100
// [RULE9] no write permission, forbidden operation or storage fault gives 2203
// [RULE10] a command carried out successfully gives result 0000
// [RULE11] area 0 after power-up; only move leaves, only reset returns; the code also leaves area 0 on front-key entry
// [RULE12] measurement runs in area 0 and is suspended in area 1
// [RULE13] area 0 refuses measurement-affecting parameter writes; reads always work; the code refuses reads with 2203 at calibration level
// [RULE14] area 1 accepts initial, communication and advanced parameter writes
// [RULE15] entering initial-setting level from front keys switches to area 1
// [RULE16] remote move to area 1 shows initial-setting level on indicator
// [RULE17] at calibration level every host control command is refused
// [RULE18] read C0 0001 returns process value, flagged unknown in area 1
// [RULE19] read C0 0002 returns comparative status, flagged unknown in area 1
// [RULE20] write C2 0000 gives remote display value; area 1 leaves display
// [RULE21] host enables write permission before sending remote value write
// [RULE22] area, permission and forced-zero change only on result 0000
package meter_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] OFF_REQ = 8'h00;
  localparam logic [7:0] OFF_ARG0 = 8'h04;
  localparam logic [7:0] OFF_ARG1 = 8'h08;
  localparam logic [7:0] OFF_WDATA = 8'h0C;
  localparam logic [7:0] OFF_GO = 8'h10;
  localparam logic [7:0] OFF_RESP = 8'h14;
  localparam logic [7:0] OFF_RDATA = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;

  // ==========================================================================
  // field positions
  localparam int REQ_LEN_LSB = 16;
  localparam int REQ_MAIN_LSB = 8;
  localparam int ARG_TYPE_LSB = 24;
  localparam int ARG_ADDR_LSB = 8;
  localparam int RESP_ECHO_LSB = 16;

  // ==========================================================================
  // request and instruction codes
  localparam logic [7:0] MAIN_OP = 8'h30;
  localparam logic [7:0] SUB_OP = 8'h05;
  localparam logic [7:0] MAIN_VAR = 8'h01;
  localparam logic [7:0] SUB_RD = 8'h01;
  localparam logic [7:0] SUB_WR = 8'h02;
  localparam logic [7:0] IC_WREN = 8'h00;
  localparam logic [7:0] IC_FZERO = 8'h03;
  localparam logic [7:0] IC_RESET = 8'h06;
  localparam logic [7:0] IC_AREA1 = 8'h07;
  localparam logic [7:0] IC_PROTECT = 8'h08;
  localparam logic [7:0] REL_OFF = 8'h00;
  localparam logic [7:0] REL_ON = 8'h01;
  localparam logic [7:0] VT_C0 = 8'hC0;
  localparam logic [7:0] VT_C1 = 8'hC1;
  localparam logic [7:0] VT_C2 = 8'hC2;
  localparam logic [7:0] VT_C3 = 8'hC3;
  localparam logic [15:0] ADDR_RIN = 16'h0000;
  localparam logic [15:0] ADDR_PV = 16'h0001;
  localparam logic [15:0] MAX_C0 = 16'h0002;
  localparam logic [15:0] MAX_C1 = 16'h0003;
  localparam logic [15:0] MAX_C2 = 16'h0006;
  localparam logic [15:0] MAX_C3 = 16'h001D;
  localparam logic [15:0] ELEM_ONE = 16'h0001;

  // ==========================================================================
  // frame body lengths in characters
  localparam logic [15:0] OP_LEN = 16'h0004;
  localparam logic [15:0] VRD_LEN = 16'h000C;
  localparam logic [15:0] VWR_LEN = 16'h0014;

  // ==========================================================================
  // result codes
  localparam logic [15:0] RC_OK = 16'h0000;
  localparam logic [15:0] RC_LONG = 16'h1001;
  localparam logic [15:0] RC_SHORT = 16'h1002;
  localparam logic [15:0] RC_PARAM = 16'h1100;
  localparam logic [15:0] RC_TYPE = 16'h1101;
  localparam logic [15:0] RC_ADDR = 16'h1103;
  localparam logic [15:0] RC_OPERR = 16'h2203;
  localparam logic [15:0] RC_RDONLY = 16'h3003;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} exec_state_t;

  typedef struct packed {
    logic protect;
    logic fzero;
    logic wr_en;
    logic area1;
    logic measuring;
  } flags_t;

  typedef struct packed {
    logic calib;
    logic nv_fail;
    logic key_init;
  } pins_t;

  typedef struct packed {
    exec_state_t st;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] req;
    logic [31:0] arg0;
    logic [31:0] arg1;
    logic [31:0] wdata;
    logic [31:0] resp;
    logic [31:0] rdata;
    logic [31:0] hrdata;
    logic [31:0] remote_value;
    flags_t flags;
    logic unknown;
    logic key_q;
    logic sw_reset;
    logic remote_strobe;
    logic param_wr;
    logic hreadyout;
  } state_t;

  localparam flags_t FLAGS_RST = 5'h01;
  localparam state_t STATE_RST = '{st: ST_IDLE, flags: FLAGS_RST,
    hreadyout: 1'b1, default: '0};

endpackage

// [hdl/pin_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 3
) (
  input logic clk,
  input logic rst,
  input logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ==========================================================================
  // level only follows once the two late stages agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_out <= '0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++)
      begin
        if (s2_q[i] == s3_q[i])
        begin
          level_out[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// [test/host_model.sv]
// host side model: bus master that issues single-word transfers
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // ==========================================================================
  // idle bus from time zero
  initial
  begin
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // ==========================================================================
  // one transfer; address held until hready, then data held until hready
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    // reads get a changing pattern so stale data never looks valid
    hwdata <= w ? d : ~hwdata;
    do @(posedge clk); while (hready !== 1'h1);
    q = hrdata;
  endtask
endmodule

// [test/panel_meter_command_layer_test.sv]
// self-checking bench of the panel meter command layer
`timescale 1ns/1ps
module panel_meter_command_layer_test;
  logic clk, rst, hsel, hwrite, hreadyout, hresp;
  wire logic hready;
  logic [31:0] haddr, hwdata, hrdata, process_value, status_word;
  logic [31:0] remote_value, q, v, pv, sw;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic key_init_pin, calib_pin, nv_fail_pin, sw_reset, remote_strobe;
  logic param_wr;
  meter_pkg::flags_t flags;
  logic [31:0] seed = 32'hC288E035;
  int n_fail = 0;
  int checks_done = 0;
  int n_pw = 0;
  int n_swr = 0;
  int n_rs = 0;

  assign hready = hreadyout;

  panel_meter_command_layer dut (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .key_init_pin(key_init_pin),
    .calib_pin(calib_pin), .nv_fail_pin(nv_fail_pin),
    .process_value(process_value), .status_word(status_word),
    .flags(flags), .sw_reset(sw_reset), .remote_value(remote_value),
    .remote_strobe(remote_strobe), .param_wr(param_wr));

  host_model host (.clk(clk), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  // ==========================================================================
  // clock and helpers
  initial clk = 1'h0;
  always #5 clk = ~clk;

  // one-cycle pulses are counted so a later look still sees them
  always @(posedge clk)
  begin
    if (param_wr === 1'h1)
      n_pw <= n_pw + 1;
    if (sw_reset === 1'h1)
      n_swr <= n_swr + 1;
    if (remote_strobe === 1'h1)
      n_rs <= n_rs + 1;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] resp_w(input logic [7:0] m,
    input logic [7:0] s, input logic [15:0] rc);
    return {m, s, rc};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmd(input logic [15:0] len, input logic [7:0] m,
    input logic [7:0] s, input logic [31:0] a0, input logic [31:0] wd,
    input logic [15:0] rc);
    logic [31:0] d;
    host.xfer(1'h1, meter_pkg::OFF_REQ, {len, m, s}, d);
    host.xfer(1'h1, meter_pkg::OFF_ARG0, a0, d);
    host.xfer(1'h1, meter_pkg::OFF_ARG1, {16'h0, meter_pkg::ELEM_ONE}, d);
    host.xfer(1'h1, meter_pkg::OFF_WDATA, wd, d);
    host.xfer(1'h1, meter_pkg::OFF_GO, 32'h1, d);
    host.xfer(1'h0, meter_pkg::OFF_RESP, 32'h0, d);
    chk("resp", resp_w(m, s, rc), d);
  endtask

  // host marks every instruction with 30 and 05
  task automatic op(input logic [15:0] len, input logic [7:0] c,
    input logic [7:0] r, input logic [15:0] rc);
    cmd(len, meter_pkg::MAIN_OP, meter_pkg::SUB_OP, {16'h0, c, r}, 32'h0,
      rc);
  endtask

  task automatic var_op(input logic w, input logic [7:0] t,
    input logic [15:0] a, input logic [31:0] wd, input logic [15:0] rc);
    cmd(w ? meter_pkg::VWR_LEN : meter_pkg::VRD_LEN, meter_pkg::MAIN_VAR,
      w ? meter_pkg::SUB_WR : meter_pkg::SUB_RD, {t, a, 8'h00}, wd, rc);
  endtask

  // pins cross a synchroniser, so give them a few edges
  task automatic pins(input logic k, input logic c, input logic n);
    @(posedge clk);
    key_init_pin <= k;
    calib_pin <= c;
    nv_fail_pin <= n;
    repeat (8) @(posedge clk);
  endtask

  // ==========================================================================
  // watchdog, far beyond the under a thousand cycles the tests need
  initial
  begin
    repeat (30000) @(posedge clk);
    n_fail++;
    results();
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    rst = 1'h1;
    key_init_pin = 1'h0;
    calib_pin = 1'h0;
    nv_fail_pin = 1'h0;
    process_value = 32'h0;
    status_word = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk("flags", {27'h0, meter_pkg::FLAGS_RST}, {27'h0, flags});
    op(16'h4, 8'h03, 8'h01, meter_pkg::RC_OPERR);
    var_op(1'h1, 8'hC2, 16'h0, 32'h5, meter_pkg::RC_OPERR);
    chk("flags", 32'h1, {27'h0, flags});
    op(16'h5, 8'h00, 8'h01, meter_pkg::RC_LONG);
    op(16'h3, 8'h00, 8'h01, meter_pkg::RC_SHORT);
    op(16'h4, 8'h05, 8'h00, meter_pkg::RC_PARAM);
    op(16'h4, 8'h00, 8'h02, meter_pkg::RC_PARAM);
    op(16'h4, 8'h06, 8'h01, meter_pkg::RC_PARAM);
    op(16'h4, 8'h07, 8'h01, meter_pkg::RC_PARAM);
    op(16'h4, 8'h00, 8'h01, meter_pkg::RC_OK);
    chk("flags", 32'h5, {27'h0, flags});
    op(16'h4, 8'h00, 8'h00, meter_pkg::RC_OK);
    chk("flags", 32'h1, {27'h0, flags});
    op(16'h4, 8'h00, 8'h01, meter_pkg::RC_OK);
    op(16'h4, 8'h03, 8'h01, meter_pkg::RC_OK);
    chk("fzero", 32'h1, {31'h0, flags.fzero});
    op(16'h4, 8'h03, 8'h00, meter_pkg::RC_OK);
    chk("fzero", 32'h0, {31'h0, flags.fzero});
    pins(1'h0, 1'h0, 1'h1);
    op(16'h4, 8'h03, 8'h01, meter_pkg::RC_OPERR);
    chk("fzero", 32'h0, {31'h0, flags.fzero});
    pins(1'h0, 1'h0, 1'h0);
    repeat (4)
    begin
      v = rnd();
      pv = rnd();
      sw = rnd();
      var_op(1'h1, 8'hC2, 16'h0, v, meter_pkg::RC_OK);
      chk("remote", v, remote_value);
      process_value <= pv;
      status_word <= sw;
      var_op(1'h0, 8'hC0, 16'h1, 32'h0, meter_pkg::RC_OK);
      host.xfer(1'h0, meter_pkg::OFF_RDATA, 32'h0, q);
      chk("pv", pv, q);
      host.xfer(1'h0, meter_pkg::OFF_STAT, 32'h0, q);
      chk("unknown", 32'h0, {31'h0, q[6]});
      var_op(1'h0, 8'hC0, 16'h2, 32'h0, meter_pkg::RC_OK);
      host.xfer(1'h0, meter_pkg::OFF_RDATA, 32'h0, q);
      chk("status", sw, q);
    end
    chk("strobes", 32'h4, n_rs);
    var_op(1'h1, 8'hC3, 16'h1, 32'h3, meter_pkg::RC_OPERR);
    op(16'h4, 8'h08, 8'h00, meter_pkg::RC_OK);
    chk("protect", 32'h1, {31'h0, flags.protect});
    op(16'h4, 8'h07, 8'h00, meter_pkg::RC_OK);
    chk("area", 32'h2, {30'h0, flags.area1, flags.measuring});
    op(16'h4, 8'h08, 8'h00, meter_pkg::RC_OPERR);
    op(16'h4, 8'h03, 8'h01, meter_pkg::RC_OPERR);
    var_op(1'h0, 8'hC0, 16'h1, 32'h0, meter_pkg::RC_OK);
    host.xfer(1'h0, meter_pkg::OFF_STAT, 32'h0, q);
    chk("unknown", 32'h1, {31'h0, q[6]});
    var_op(1'h0, 8'hC0, 16'h2, 32'h0, meter_pkg::RC_OK);
    host.xfer(1'h0, meter_pkg::OFF_STAT, 32'h0, q);
    chk("unknown", 32'h1, {31'h0, q[6]});
    var_op(1'h1, 8'hC2, 16'h0, ~v, meter_pkg::RC_OK);
    chk("strobes", 32'h4, n_rs);
    chk("remote", v, remote_value);
    var_op(1'h1, 8'hC3, 16'h1, 32'h3, meter_pkg::RC_OK);
    chk("param_wr", 32'h1, n_pw);
    op(16'h4, 8'h06, 8'h00, meter_pkg::RC_OK);
    chk("sw_reset", 32'h1, n_swr);
    chk("flags", {27'h0, meter_pkg::FLAGS_RST}, {27'h0, flags});
    op(16'h4, 8'h07, 8'h00, meter_pkg::RC_OPERR);
    chk("area1", 32'h0, {31'h0, flags.area1});
    pins(1'h1, 1'h0, 1'h0);
    chk("area1", 32'h1, {31'h0, flags.area1});
    pins(1'h0, 1'h1, 1'h0);
    op(16'h4, 8'h00, 8'h01, meter_pkg::RC_OPERR);
    chk("flags", 32'h0, {31'h0, flags.wr_en});
    pins(1'h0, 1'h0, 1'h0);
    host.xfer(1'h0, 8'h40, 32'h0, q);
    chk("unmapped", 32'h0, q);
    chk("hresp", 32'h0, {31'h0, hresp});
    results();
  end
endmodule
